/* File: core/ulsf_line_status.sv */
`timescale 1ns/1ps
`include "ulsf_regs.svh"

//------------------------------------------------------------
// Notes on behaviour
// - Break also raises parity error flag
// - Status word read clears parity error
// - Single mode: unread character sets overrun
// - Single-mode overrun overwrites receive buffer
// - FIFO mode: full FIFO plus character overruns
// - FIFO overrun keeps entries, drops new
// - Status word read clears overrun
// - Ready high while any character waits
// - Single mode: buffer read clears ready
// - FIFO mode: ready clears when empty
// - Break after low beyond character time
// - FIFO errors travel with their character
//------------------------------------------------------------

module ulsf_line_status (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  // Serial line and sample tick
  input  wire logic       RX_PIN,
  input  wire logic       RX_TICK,
  // Character from the receive shifter
  input  wire logic       CHAR_DONE,
  input  wire logic [7:0] CHAR_DATA,
  input  wire logic       CHAR_PAR_ERR,
  input  wire logic       CHAR_FRM_ERR,
  // Configuration
  input  wire logic       FIFO_MODE,
  // Software accesses
  input  wire logic       LSW_RD,
  input  wire logic       RBUF_RD,
  // Status and data out
  output logic [7:0]      LINE_STATUS_WORD,
  output logic [7:0]      RECEIVE_BUFFER
);

  //----------------------------------------------------------
  // Pin synchroniser
  //----------------------------------------------------------
  logic rx_meta_q;
  logic rx_sync_q;

  // Two stages before anything looks at the pin
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= RX_PIN;
      rx_sync_q <= rx_meta_q;
    end
  end

  //----------------------------------------------------------
  // Break detection
  //----------------------------------------------------------
  logic brk_pulse;

  ulsf_break_det u_brk (
    .clk       (CORE_CLK),
    .rst       (RST),
    .line_low  (!rx_sync_q),
    .tick      (RX_TICK),
    .brk_pulse (brk_pulse)
  );

  //----------------------------------------------------------
  // Storage
  //----------------------------------------------------------
  ulsf_pkg::ulsf_entry_t        mem_q [`ULSF_FIFO_DEPTH];
  logic [`ULSF_PTR_W-1:0]       wr_ptr_q;
  logic [`ULSF_PTR_W-1:0]       rd_ptr_q;
  logic [`ULSF_CNT_W-1:0]       cnt_q;
  ulsf_pkg::ulsf_entry_t        sbuf_q;
  logic                         sfull_q;
  ulsf_pkg::ulsf_entry_t        new_entry;
  ulsf_pkg::ulsf_mode_t         mode;
  logic                         fifo_full;
  logic                         fifo_empty;
  logic                         push;
  logic                         pop;
  logic                         overrun_evt;
  logic                         head_valid;
  ulsf_pkg::ulsf_entry_t        head;

  // Pointer step shared by both pointers
  function automatic logic [`ULSF_PTR_W-1:0] ptr_inc(input logic [`ULSF_PTR_W-1:0] p);
    ptr_inc = p + `ULSF_PTR_W'(1);
  endfunction : ptr_inc

  // Break arrives as a null character marked bad
  always_comb begin
    mode = ulsf_pkg::ulsf_mode_t'(FIFO_MODE);
    new_entry.data = brk_pulse ? 8'h00 : CHAR_DATA;
    new_entry.brk  = brk_pulse;
    new_entry.frm  = brk_pulse | CHAR_FRM_ERR;
    new_entry.par  = brk_pulse | CHAR_PAR_ERR;
  end

  assign fifo_full  = (cnt_q == `ULSF_CNT_W'(`ULSF_FIFO_DEPTH));
  assign fifo_empty = (cnt_q == '0);
  assign pop        = (mode == ulsf_pkg::ULSF_MODE_FIFO) && RBUF_RD && !fifo_empty;
  // A pop in the same cycle frees a slot, so no overrun then
  assign push       = (mode == ulsf_pkg::ULSF_MODE_FIFO) && (CHAR_DONE || brk_pulse)
                      && (!fifo_full || pop);
  assign overrun_evt = (CHAR_DONE || brk_pulse) && (
                       (mode == ulsf_pkg::ULSF_MODE_FIFO) ? (fifo_full && !pop)
                       : (sfull_q && !RBUF_RD));
  assign head       = mem_q[rd_ptr_q];
  assign head_valid = !fifo_empty;

  // FIFO array; full-FIFO characters are dropped, entries untouched
  always_ff @(posedge CORE_CLK) begin
    if (push) begin
      mem_q[wr_ptr_q] <= new_entry;
    end
  end

  // FIFO pointers and fill count
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else if (mode != ulsf_pkg::ULSF_MODE_FIFO) begin
      // Leaving FIFO mode flushes it
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= ptr_inc(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= ptr_inc(rd_ptr_q);
      end
      // Count moves only on an unmatched push or pop
      unique case ({push, pop})
        2'b10:   cnt_q <= cnt_q + `ULSF_CNT_W'(1);
        2'b01:   cnt_q <= cnt_q - `ULSF_CNT_W'(1);
        default: cnt_q <= cnt_q;
      endcase
    end
  end

  // Single holding buffer; in single mode a new character always lands here
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sbuf_q  <= '0;
      sfull_q <= 1'b0;
    end else if (mode == ulsf_pkg::ULSF_MODE_SINGLE) begin
      if (CHAR_DONE || brk_pulse) begin
        sbuf_q  <= new_entry;
        sfull_q <= 1'b1;
      end else if (RBUF_RD) begin
        sfull_q <= 1'b0;
      end
    end else begin
      sfull_q <= 1'b0;
    end
  end

  //----------------------------------------------------------
  // Next FIFO head
  //----------------------------------------------------------
  logic [`ULSF_PTR_W-1:0] head_ptr_d;
  logic [7:0]             head_data_d;

  // Slot that is head after this edge; a character written into that
  // very slot bypasses the array, else the buffer would lag a cycle
  // and show a stale or never-written slot first
  always_comb begin
    head_ptr_d = pop ? ptr_inc(rd_ptr_q) : rd_ptr_q;
    if (push && (wr_ptr_q == head_ptr_d)) begin
      head_data_d = new_entry.data;
    end else begin
      head_data_d = mem_q[head_ptr_d].data;
    end
  end

  //----------------------------------------------------------
  // Sticky error flags
  //----------------------------------------------------------
  logic par_q;
  logic frm_q;
  logic brk_q;
  logic ovr_q;
  logic par_set;
  logic frm_set;
  logic brk_set;
  logic par_d;
  logic frm_d;
  logic brk_d;
  logic ovr_d;

  // Single mode flags at once; FIFO mode only when a char reaches the head
  logic head_new_q;
  logic head_shown_q;

  // Track whether the current head has already posted its marks
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      head_shown_q <= 1'b0;
    end else if (pop || !head_valid || mode != ulsf_pkg::ULSF_MODE_FIFO) begin
      head_shown_q <= 1'b0;
    end else begin
      head_shown_q <= 1'b1;
    end
  end

  assign head_new_q = head_valid && !head_shown_q && (mode == ulsf_pkg::ULSF_MODE_FIFO);

  always_comb begin
    if (mode == ulsf_pkg::ULSF_MODE_FIFO) begin
      par_set = head_new_q && head.par;
      frm_set = head_new_q && head.frm;
      brk_set = head_new_q && head.brk;
    end else begin
      par_set = (CHAR_DONE || brk_pulse) && new_entry.par;
      frm_set = (CHAR_DONE || brk_pulse) && new_entry.frm;
      brk_set = brk_pulse;
    end
  end

  // Set wins over the clearing status read, so no event is lost
  // Shared by the flag flops and the status word
  always_comb begin
    par_d = par_set | (par_q & ~LSW_RD);
    frm_d = frm_set | (frm_q & ~LSW_RD);
    brk_d = brk_set | (brk_q & ~LSW_RD);
    ovr_d = overrun_evt | (ovr_q & ~LSW_RD);
  end

  // Flag flops
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      par_q <= 1'b0;
      frm_q <= 1'b0;
      brk_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      par_q <= par_d;
      frm_q <= frm_d;
      brk_q <= brk_d;
      ovr_q <= ovr_d;
    end
  end

  //----------------------------------------------------------
  // Registered outputs
  //----------------------------------------------------------
  logic ready_d;

  // Ready follows holding buffer or FIFO occupancy of the next cycle
  always_comb begin
    if (mode == ulsf_pkg::ULSF_MODE_FIFO) begin
      // Empty after this cycle when none left and no push, or one left, popped, and no push
      ready_d = !((cnt_q == '0 && !push) ||
                  (cnt_q == `ULSF_CNT_W'(1) && pop && !push));
    end else begin
      ready_d = (CHAR_DONE || brk_pulse) || (sfull_q && !RBUF_RD);
    end
  end

  // Status word takes the values the flag flops take at this edge
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      LINE_STATUS_WORD <= 8'h00;
    end else begin
      LINE_STATUS_WORD <= 8'h00;
      LINE_STATUS_WORD[`ULSF_LSW_READY_BIT]   <= ready_d;
      LINE_STATUS_WORD[`ULSF_LSW_OVERRUN_BIT] <= ovr_d;
      LINE_STATUS_WORD[`ULSF_LSW_PARITY_BIT]  <= par_d;
      LINE_STATUS_WORD[`ULSF_LSW_FRAMING_BIT] <= frm_d;
      LINE_STATUS_WORD[`ULSF_LSW_BREAK_BIT]   <= brk_d;
    end
  end

  // Receive buffer shows the holding buffer or the next FIFO head
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      RECEIVE_BUFFER <= 8'h00;
    end else if (mode == ulsf_pkg::ULSF_MODE_FIFO) begin
      // Keep the last character once drained; the array has no reset
      if (ready_d) begin
        RECEIVE_BUFFER <= head_data_d;
      end
    end else begin
      RECEIVE_BUFFER <= (CHAR_DONE || brk_pulse) ? new_entry.data : sbuf_q.data;
    end
  end

endmodule : ulsf_line_status

/* File: core/ulsf_regs.svh */
`ifndef ULSF_REGS_SVH
`define ULSF_REGS_SVH

// Line status word bit positions
`define ULSF_LSW_READY_BIT   0
`define ULSF_LSW_OVERRUN_BIT 1
`define ULSF_LSW_PARITY_BIT  2
`define ULSF_LSW_FRAMING_BIT 3
`define ULSF_LSW_BREAK_BIT   4

// Receive FIFO geometry
`define ULSF_FIFO_DEPTH      16
`define ULSF_PTR_W           4
`define ULSF_CNT_W           5

// Character shape: start + 8 data + parity + 2 stop, in sample ticks (16 per bit)
`define ULSF_CHAR_BITS       12
`define ULSF_TICKS_PER_BIT   16
`define ULSF_BREAK_TICKS     (`ULSF_CHAR_BITS * `ULSF_TICKS_PER_BIT)
`define ULSF_BREAK_CNT_W     9

`endif

/* File: core/ulsf_pkg.sv */
package ulsf_pkg;
  // Receive path organisation
  typedef enum logic [0:0] {
    ULSF_MODE_SINGLE = 1'b0,
    ULSF_MODE_FIFO   = 1'b1
  } ulsf_mode_t;

  // One stored character with its error marks
  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } ulsf_entry_t;
endpackage : ulsf_pkg

/* File: core/ulsf_break_det.sv */
`timescale 1ns/1ps
`include "ulsf_regs.svh"

// Break detector: counts sample ticks while the line sits low
module ulsf_break_det (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Line and timing
  input  wire logic line_low,
  input  wire logic tick,
  // Result
  output logic      brk_pulse
);

  logic [`ULSF_BREAK_CNT_W-1:0] cnt_q;
  logic                         fired_q;

  // Low-time counter, saturates after firing once per low period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q     <= '0;
      fired_q   <= 1'b0;
      brk_pulse <= 1'b0;
    end else begin
      brk_pulse <= 1'b0;
      if (!line_low) begin
        cnt_q   <= '0;
        fired_q <= 1'b0;
      end else if (tick && !fired_q) begin
        // Strictly longer than a full character time
        if (cnt_q == `ULSF_BREAK_CNT_W'(`ULSF_BREAK_TICKS)) begin
          brk_pulse <= 1'b1;
          fired_q   <= 1'b1;
        end else begin
          cnt_q <= cnt_q + `ULSF_BREAK_CNT_W'(1);
        end
      end
    end
  end

endmodule : ulsf_break_det

/* File: sim/ulsf_line_status_assertions.sv */
`timescale 1ns/1ps
module ulsf_line_status_chk (
  // Clock and reset
  input wire logic       CORE_CLK,
  input wire logic       RST,
  // Stimulus side
  input wire logic       RX_PIN,
  input wire logic       CHAR_DONE,
  input wire logic [7:0] CHAR_DATA,
  input wire logic       CHAR_PAR_ERR,
  input wire logic       FIFO_MODE,
  input wire logic       LSW_RD,
  input wire logic       RBUF_RD,
  // Status and data
  input wire logic [7:0] LINE_STATUS_WORD,
  input wire logic [7:0] RECEIVE_BUFFER
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic sgl;
  // -------------------------------------------------
  // Single buffer; line kept high so no break sneaks in
  // -------------------------------------------------
  assign sgl = ~FIFO_MODE;
  ready_set_a: assert property (sgl && CHAR_DONE |=> LINE_STATUS_WORD[0])
    else $error("ready flag missing");
  parity_set_a: assert property (sgl && CHAR_DONE && CHAR_PAR_ERR |=> LINE_STATUS_WORD[2])
    else $error("parity flag missing");
  overrun_set_a: assert property (sgl && CHAR_DONE && LINE_STATUS_WORD[0] && !RBUF_RD
    |=> LINE_STATUS_WORD[1]) else $error("overrun flag missing");
  buffer_load_a: assert property (sgl && CHAR_DONE |=> RECEIVE_BUFFER == $past(CHAR_DATA))
    else $error("buffer not overwritten");
  flags_clear_a: assert property (sgl && LSW_RD && !CHAR_DONE && RX_PIN
    |=> LINE_STATUS_WORD[2:1] == 2'b00) else $error("status read kept flags");
  ready_clear_a: assert property (sgl && RBUF_RD && !CHAR_DONE && RX_PIN
    |=> !LINE_STATUS_WORD[0]) else $error("buffer read kept ready");
  // -------------------------------------------------
  // Queue mode: no pop means head and ready hold
  // -------------------------------------------------
  fifo_ready_a: assert property (FIFO_MODE && $past(FIFO_MODE) && LINE_STATUS_WORD[0] && !RBUF_RD
    |=> LINE_STATUS_WORD[0] || !FIFO_MODE) else $error("ready dropped early");
  fifo_head_a: assert property (FIFO_MODE && $past(FIFO_MODE) && LINE_STATUS_WORD[0] && !RBUF_RD
    |=> $stable(RECEIVE_BUFFER) || !FIFO_MODE) else $error("head changed");
  break_parity_a: assert property (LINE_STATUS_WORD[4] |-> LINE_STATUS_WORD[2])
    else $error("break without parity flag");
  cover property (FIFO_MODE && LINE_STATUS_WORD[1]);
  cover property (LINE_STATUS_WORD[4]);
  cover property (sgl && CHAR_DONE && LSW_RD);
endmodule : ulsf_line_status_chk

bind ulsf_line_status ulsf_line_status_chk u_chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .RX_PIN(RX_PIN), .CHAR_DONE(CHAR_DONE), .CHAR_DATA(CHAR_DATA), .CHAR_PAR_ERR(CHAR_PAR_ERR),
  .FIFO_MODE(FIFO_MODE), .LSW_RD(LSW_RD), .RBUF_RD(RBUF_RD),
  .LINE_STATUS_WORD(LINE_STATUS_WORD), .RECEIVE_BUFFER(RECEIVE_BUFFER));

/* File: sim/ulsf_remote_tx.sv */
`timescale 1ns/1ps
module ulsf_remote_tx (
  // Clock
  input  wire logic  clk,
  // Serial line and sample tick
  output logic       rx_pin,
  output logic       rx_tick,
  // Completed character
  output logic       char_done,
  output logic [7:0] char_data,
  output logic       char_par_err,
  output logic       char_frm_err
);
  // Idle line high, no character
  initial begin
    rx_pin = 1'b1;
    rx_tick = 1'b0;
    char_done = 1'b0;
    char_data = 8'h00;
    char_par_err = 1'b0;
    char_frm_err = 1'b0;
  end
  // Tick every other cycle keeps break runs short
  always @(posedge clk) rx_tick <= ~rx_tick;
  // One character; fields turn to junk once released
  task send(input logic [7:0] d, input logic pe, input logic fe);
    @(posedge clk);
    char_done <= 1'b1;
    char_data <= d;
    char_par_err <= pe;
    char_frm_err <= fe;
    @(posedge clk);
    char_done <= 1'b0;
    char_data <= ~d;
    char_par_err <= ~pe;
    char_frm_err <= ~fe;
  endtask : send
  // Line held low past a whole character
  task hold_low(input int n);
    @(posedge clk);
    rx_pin <= 1'b0;
    repeat (n) @(posedge clk);
    rx_pin <= 1'b1;
  endtask : hold_low
endmodule : ulsf_remote_tx

/* File: sim/ulsf_line_status_bench.sv */
`timescale 1ns/1ps
module ulsf_line_status_bench;
  logic clk, rst, fifo_mode, lsw_rd, rbuf_rd, rx_pin, rx_tick, done, pe, fe;
  logic [7:0] data, lsw, rbuf;
  int miscompares = 0;
  int samples_checked = 0;
  ulsf_remote_tx tx (.clk(clk), .rx_pin(rx_pin), .rx_tick(rx_tick), .char_done(done),
    .char_data(data), .char_par_err(pe), .char_frm_err(fe));
  ulsf_line_status DUT (.CORE_CLK(clk), .RST(rst), .RX_PIN(rx_pin), .RX_TICK(rx_tick),
    .CHAR_DONE(done), .CHAR_DATA(data), .CHAR_PAR_ERR(pe), .CHAR_FRM_ERR(fe),
    .FIFO_MODE(fifo_mode), .LSW_RD(lsw_rd), .RBUF_RD(rbuf_rd),
    .LINE_STATUS_WORD(lsw), .RECEIVE_BUFFER(rbuf));
  // -------------------------------------------------
  // Access and compare tasks
  // -------------------------------------------------
  task rd(input logic status);
    @(posedge clk);
    if (status) lsw_rd <= 1'b1;
    else rbuf_rd <= 1'b1;
    @(posedge clk);
    lsw_rd <= 1'b0;
    rbuf_rd <= 1'b0;
  endtask : rd
  // Sample at the falling edge, well clear of updates
  task chk_lsw(input logic [7:0] exp);
    @(negedge clk);
    samples_checked++;
    if (lsw !== exp) begin
      miscompares++;
      $display("unexpected status at %0t: got %h expected %h", $time, lsw, exp);
    end
  endtask : chk_lsw
  task chk_buf(input logic [7:0] exp);
    @(negedge clk);
    samples_checked++;
    if (rbuf !== exp) begin
      miscompares++;
      $display("unexpected data at %0t: got %h expected %h", $time, rbuf, exp);
    end
  endtask : chk_buf
  task finish_test();
    $display("checked %0d, miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // -------------------------------------------------
  // Clock, guard and main sequence
  // -------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    fifo_mode = 1'b0;
    lsw_rd = 1'b0;
    rbuf_rd = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk_lsw(8'h00);
    tx.send(8'hA5, 1'b1, 1'b0);
    chk_lsw(8'h05);
    tx.send(8'h3C, 1'b0, 1'b0);
    chk_lsw(8'h07);
    chk_buf(8'h3C);
    rd(1'b1);
    chk_lsw(8'h01);
    rd(1'b0);
    chk_lsw(8'h00);
    // Error and clearing read land on one edge
    fork
      tx.send(8'h11, 1'b1, 1'b0);
      rd(1'b1);
    join
    chk_lsw(8'h05);
    // Buffer read and new character on one edge: no overrun
    fork
      tx.send(8'h22, 1'b0, 1'b0);
      rd(1'b0);
    join
    chk_lsw(8'h05);
    chk_buf(8'h22);
    rd(1'b1);
    rd(1'b0);
    tx.hold_low(420);
    chk_lsw(8'h1D);
    chk_buf(8'h00);
    rd(1'b1);
    rd(1'b0);
    @(posedge clk) fifo_mode <= 1'b1;
    tx.send(8'h40, 1'b1, 1'b0);
    chk_buf(8'h40);
    for (int i = 1; i < 16; i++) tx.send(8'(8'h40 + i), 1'b0, i == 1);
    chk_lsw(8'h05);
    tx.send(8'hEE, 1'b0, 1'b0);
    chk_lsw(8'h07);
    rd(1'b1);
    chk_lsw(8'h01);
    for (int i = 0; i < 16; i++) begin
      chk_buf(8'(8'h40 + i));
      chk_lsw(i >= 1 ? 8'h09 : 8'h01);
      rd(1'b0);
    end
    chk_lsw(8'h08);
    // Break in FIFO mode posts its marks once it is head
    tx.hold_low(420);
    chk_lsw(8'h1D);
    chk_buf(8'h00);
    rd(1'b1);
    chk_lsw(8'h01);
    rd(1'b0);
    chk_lsw(8'h00);
    finish_test();
  end
endmodule : ulsf_line_status_bench
